// file: inc/slc_defs.svh
`ifndef SLC_DEFS_SVH
`define SLC_DEFS_SVH

// register indices on the plain port
`define SLC_ADR_RSVD_A      8'h10
`define SLC_ADR_RSVD_B      8'h11
`define SLC_ADR_DBG_SRC     8'h1f
`define SLC_ADR_DIR_LO      8'h0c
`define SLC_ADR_DIR_HI      8'h0d
`define SLC_ADR_LSTAT_BASE  8'h20
`define SLC_ADR_PSTAT_BASE  8'h40
`define SLC_ADR_LCFG_BASE   8'h80
`define SLC_ADR_STAT_BASE   8'ha0

// status field positions
`define SLC_ST_TGT_LSB      24
`define SLC_ST_DEST_LSB     16
`define SLC_ST_DIR_LSB      8
`define SLC_ST_NET_LSB      4
`define SLC_ST_JUNK         2
`define SLC_ST_DBUSY        1
`define SLC_ST_SBUSY        0

// link configuration field positions
`define SLC_CF_EN           31
`define SLC_CF_WIRE5        30
`define SLC_CF_ERR          27
`define SLC_CF_CRED_OUT     26
`define SLC_CF_CRED_IN      25
`define SLC_CF_CREDIT_REQUEST_TOKEN        24
`define SLC_CF_RXRST        23
`define SLC_CF_SGAP_LSB     11
`define SLC_CF_TGAP_LSB     0

// static forwarding field positions
`define SLC_SF_EN           31
`define SLC_SF_PROC         8
`define SLC_SF_CHAN_LSB     0

// debug source bit positions
`define SLC_DS_SPARE        4
`define SLC_DS_CORE1        1
`define SLC_DS_CORE0        0

// reset values
`define SLC_RST_DIR         4'h0
`define SLC_RST_NET         2'h0
`define SLC_RST_GAP         11'h000
`define SLC_RST_CHAN        5'h00

`endif

// file: inc/slc_pkg.sv
package slc_pkg;

	// what feeds a link's source side
	typedef enum logic [1:0] {
		SLC_TGT_EXTERNAL,
		SLC_TGT_PROCESSOR,
		SLC_TGT_SWITCH_CTRL,
		SLC_TGT_UNDEFINED
	} slc_tgt_e;

	typedef logic [3:0]  slc_dir_t;   // routing direction
	typedef logic [1:0]  slc_net_t;   // network number
	typedef logic [10:0] slc_gap_t;   // idle gap setting
	typedef logic [11:0] slc_cnt_t;   // idle gap counter

endpackage

// file: test/slc_far_link.sv
`timescale 1ns/1ps
`default_nettype none

module slc_far_link (
	input  wire logic clk_sys,
	input  wire logic reset,
	input  wire logic helloOut,
	input  wire logic creditOut,
	input  wire logic slow,
	input  wire logic sendHello,
	output logic      rxCredit,
	output logic      rxHello,
	output logic      farCredit
);
	logic [3:0] wait_ff; // cycles until credit answer

	// answer a credit_request_token with credit, prompt or slow
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wait_ff <= 4'h0;
		end else if (helloOut) begin
			wait_ff <= slow ? 4'h9 : 4'h1;
		end else if (wait_ff != 4'h0) begin
			wait_ff <= wait_ff - 4'h1;
		end
	end
	assign rxCredit = (wait_ff == 4'h1);
	assign rxHello  = sendHello && !reset;

	// own credit_request_token drops credit, credit token grants it
	always_ff @(posedge clk_sys) begin
		if (reset || sendHello) begin
			farCredit <= 1'b0;
		end else if (creditOut) begin
			farCredit <= 1'b1;
		end
	end
endmodule

`default_nettype wire

// file: test/slc_link_cfg_props.sv
`timescale 1ns/1ps
`default_nettype none

module slc_link_cfg_props
	import slc_pkg::*;
(
	input wire logic            clk_sys,
	input wire logic            reset,
	input wire logic [7:0]      regAddr,
	input wire logic [31:0]     regWrData,
	input wire logic            regWrStb,
	input wire logic            regRdStb,
	input wire logic [31:0]     regRdData,
	input wire logic            dbgEvtCore0,
	input wire logic            dbgEvtCore1,
	input wire logic [7:0][3:0] extDirection,
	input wire logic [7:0][1:0] procNetwork,
	input wire logic [7:0]      rxHelloIn,
	input wire logic [7:0]      txSymLast,
	input wire logic [7:0]      txSymGo,
	input wire logic [7:0]      txHelloSend,
	input wire logic [7:0]      txCreditSend,
	input wire logic [7:0]      rxResetPulse,
	input wire logic [7:0]      linkEnable,
	input wire logic [7:0]      linkWire5,
	input wire logic [7:0]      staticEn,
	input wire logic [7:0][4:0] staticChan,
	input wire logic [15:0]     nodeId,
	input wire logic [15:0]     pktDestNode,
	input wire logic [3:0]      routeDir,
	input wire logic            routeLocal
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);

	logic [10:0] sGap_ff;    // link 0 symbol gap
	logic [10:0] tGap_ff;    // link 0 token gap
	slc_cnt_t    idle_ff;    // idle cycles since last symbol
	logic        wasLast_ff; // last symbol closed a token

	// shadow of link 0 gap settings
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			sGap_ff <= 11'h000;
			tGap_ff <= 11'h000;
		end else if (regWrStb && regAddr == 8'h80) begin
			sGap_ff <= regWrData[21:11];
			tGap_ff <= regWrData[10:0];
		end
	end

	// idle count, saturating, restarted by each symbol
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			idle_ff    <= 12'hfff;
			wasLast_ff <= 1'b0;
		end else if (txSymGo[0]) begin
			idle_ff    <= 12'h000;
			wasLast_ff <= txSymLast[0];
		end else if (idle_ff != 12'hfff) begin
			idle_ff <= idle_ff + 12'h001;
		end
	end

	chk_read_idle_zero: assert property (!$past(regRdStb) |-> regRdData == 32'h0)
		else $error("read data not zero outside read");
	chk_sym_gap_min: assert property (txSymGo[0] |-> idle_ff > {1'b0, wasLast_ff ? tGap_ff : sGap_ff})
		else $error("symbol gap too short");
	chk_go_needs_en: assert property (txSymGo[0] |-> linkEnable[0])
		else $error("symbol sent on disabled link");
	chk_credit_request_token_send: assert property (regWrStb && regAddr == 8'h80 && regWrData[24] |=> txHelloSend[0])
		else $error("credit_request_token not sent");
	chk_credit_answer: assert property (rxHelloIn[0] && linkEnable[0] |=> txCreditSend[0])
		else $error("credit not issued");
	chk_rx_reset: assert property (regWrStb && regAddr == 8'h80 && regWrData[23] |=> rxResetPulse[0])
		else $error("receiver reset missing");
	chk_dbg_core1: assert property (regRdStb && regAddr == 8'h1f && !$past(dbgEvtCore0)
		&& !$past(dbgEvtCore1) && $past(dbgEvtCore1, 2) && !$past(dbgEvtCore0, 2)
		|=> regRdData[1:0] == 2'b10)
		else $error("debug source wrong");
	chk_dir_field: assert property (regWrStb && regAddr == 8'h20 |=> extDirection[0] == $past(regWrData[11:8]))
		else $error("direction field wrong");
	chk_net_field: assert property (regWrStb && regAddr == 8'h40 |=> procNetwork[0] == $past(regWrData[5:4]))
		else $error("network field wrong");
	chk_en_wire: assert property (regWrStb && regAddr == 8'h83
		|=> linkEnable[3] == $past(regWrData[31]) && linkWire5[3] == $past(regWrData[30]))
		else $error("enable or width wrong");
	chk_static_map: assert property (regWrStb && regAddr == 8'ha0
		|=> staticEn[2] == $past(regWrData[31]) && staticChan[2] == $past(regWrData[4:0]))
		else $error("static link C wrong");
	chk_route_local: assert property (nodeId == pktDestNode |=> routeLocal && routeDir == 4'h0)
		else $error("local route wrong");

	cov_sym: cover property (txSymGo[0] ##[1:8] txSymGo[0]);
	cov_credit: cover property (txCreditSend[0]);
	cov_route: cover property (!routeLocal && routeDir == 4'hf);
endmodule

bind slc_link_cfg slc_link_cfg_props u_slc_link_cfg_props (.clk_sys, .reset, .regAddr, .regWrData,
	.regWrStb, .regRdStb, .regRdData, .dbgEvtCore0, .dbgEvtCore1, .extDirection, .procNetwork,
	.rxHelloIn, .txSymLast, .txSymGo, .txHelloSend, .txCreditSend, .rxResetPulse, .linkEnable,
	.linkWire5, .staticEn, .staticChan, .nodeId, .pktDestNode, .routeDir, .routeLocal);

`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top
	import slc_pkg::*;
;
	logic            clk_sys = 1'b0;
	logic            reset = 1'b1;
	logic [7:0]      regAddr = 8'h00;
	logic [31:0]     regWrData = 32'h0, regRdData;
	logic            regWrStb = 1'b0, regRdStb = 1'b0, dbgEvtCore0 = 1'b0, dbgEvtCore1 = 1'b0;
	logic [7:0][1:0] extTgtType = 16'h0, procTgtType = 16'h0, extNetwork, procNetwork;
	logic [7:0][7:0] extDestLink = 64'h0, procDestLink = 64'h0;
	logic [7:0]      extJunk = 8'h0, extDestBusy = 8'h0, extSrcBusy = 8'h0, procJunk = 8'h0;
	logic [7:0]      procDestBusy = 8'h0, procSrcBusy = 8'h0, rxOverflow = 8'h0, rxBadToken = 8'h0;
	logic [7:0]      txSymReq = 8'h0, txSymLast = 8'h0, rxCreditIn, rxHelloIn;
	logic [7:0]      txSymGo, txHelloSend, txCreditSend, rxResetPulse, linkEnable, linkWire5;
	logic [7:0]      staticEn, staticProc;
	logic [7:0][3:0] extDirection;
	logic [7:0][4:0] staticChan;
	logic [15:0]     nodeId = 16'ha5a5, pktDestNode = 16'ha5a5;
	logic [3:0]      routeDir;
	logic            routeLocal, slow = 1'b0, sendHello = 1'b0, pCred, pHello, farCred;
	int              n_fail = 0, n_checks = 0, cyc = 0;

	slc_link_cfg u_slc_link_cfg (.clk_sys, .reset, .regAddr, .regWrData, .regWrStb, .regRdStb,
		.regRdData, .dbgEvtCore0, .dbgEvtCore1, .extTgtType, .extDestLink, .extJunk, .extDestBusy,
		.extSrcBusy, .extDirection, .extNetwork, .procTgtType, .procDestLink, .procJunk,
		.procDestBusy, .procSrcBusy, .procNetwork, .rxOverflow, .rxBadToken, .rxCreditIn,
		.rxHelloIn, .txSymReq, .txSymLast, .txSymGo, .txHelloSend, .txCreditSend, .rxResetPulse,
		.linkEnable, .linkWire5, .staticEn, .staticProc, .staticChan, .nodeId, .pktDestNode,
		.routeDir, .routeLocal);
	slc_far_link u_slc_far_link (.clk_sys, .reset, .helloOut(txHelloSend[0]),
		.creditOut(txCreditSend[0]), .slow, .sendHello, .rxCredit(pCred), .rxHello(pHello),
		.farCredit(farCred));
	assign rxCreditIn = {7'h0, pCred};
	assign rxHelloIn  = {7'h0, pHello};

	// free running clock and hang guard
	always #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 4000) begin
			n_fail++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one-cycle bus write and read
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		regWrStb  <= 1'b1;
		regAddr   <= a;
		regWrData <= d;
		@(posedge clk_sys);
		regWrStb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		regRdStb <= 1'b1;
		regAddr  <= a;
		@(posedge clk_sys);
		regRdStb <= 1'b0;
		#1;
		d = regRdData;
	endtask

	// measure cycles between two symbols on link 0
	task automatic gap(input logic [31:0] e);
		int n;
		for (int k = 0; k < 2; k++) begin
			n = 0;
			do begin
				@(negedge clk_sys);
				n++;
			end while (txSymGo[0] !== 1'b1 && n < 50);
		end
		chk("symbol spacing", e, 32'(n));
	endtask

	task automatic wait_cred(output logic [31:0] d);
		int n;
		n = 0;
		do begin
			rd(8'h80, d);
			n++;
		end while (d[25] !== 1'b1 && n < 20);
		chk("credit held", 32'h1, {31'h0, d[25]});
	endtask

	task automatic t_reset();
		logic [31:0] d;
		logic [7:0] ad [9] = '{8'h10, 8'h11, 8'h1f, 8'h20, 8'h40, 8'h80, 8'ha0, 8'h0c, 8'h60};
		foreach (ad[i]) begin
			rd(ad[i], d);
			chk("reset value", 32'h0, d);
		end
		$display("test reset done");
	endtask

	task automatic t_status();
		logic [31:0] d;
		wr(8'h20, 32'hffffffff);
		wr(8'h47, 32'hffffffff);
		wr(8'h40, 32'h00000010);
		extDestLink[0]  <= 8'h5a;
		extJunk         <= 8'h01;
		extSrcBusy      <= 8'h01;
		procTgtType[7]  <= 2'h1;
		procDestLink[7] <= 8'h33;
		procDestBusy    <= 8'h80;
		for (int k = 0; k < 4; k++) begin
			@(posedge clk_sys);
			extTgtType[0] <= 2'(k);
			rd(8'h20, d);
			chk("link status", {6'h0, 2'(k), 24'h5a0f35}, d);
		end
		rd(8'h47, d);
		chk("processor_link status", 32'h01330032, d);
		rd(8'h40, d);
		chk("processor_link network", 32'h00000010, d);
		chk("network port", 32'h1, {30'h0, procNetwork[0]});
		chk("ext link port", 32'h3f, {26'h0, extNetwork[0], extDirection[0]});
		$display("test status done");
	endtask

	task automatic t_cfg();
		logic [31:0] d;
		wr(8'h83, 32'hffffffff);
		rd(8'h83, d);
		chk("config rw", 32'hc03fffff, d);
		chk("enable port", 32'h3, {30'h0, linkEnable[3], linkWire5[3]});
		wr(8'h83, 32'h0);
		rd(8'h83, d);
		chk("config off", 32'h0, {d[31:30], linkEnable[3]});
		wr(8'h10, 32'hffffffff);
		rd(8'h10, d);
		chk("reserved reg", 32'h3, d);
		$display("test config done");
	endtask

	task automatic t_credit();
		logic [31:0] d;
		wr(8'h80, 32'h81001001);
		wait_cred(d);
		@(posedge clk_sys);
		txSymReq <= 8'h01;
		gap(32'h4);
		@(posedge clk_sys);
		txSymLast <= 8'h01;
		gap(32'h3);
		@(posedge clk_sys);
		txSymReq <= 8'h00;
		sendHello <= 1'b1;
		@(posedge clk_sys);
		sendHello <= 1'b0;
		rd(8'h80, d);
		chk("credit given", 32'h1, {31'h0, d[26]});
		chk("far credit", 32'h1, {31'h0, farCred});
		@(posedge clk_sys);
		rxOverflow <= 8'h01;
		@(posedge clk_sys);
		rxOverflow <= 8'h00;
		rd(8'h80, d);
		chk("overflow flag", 32'h1, {31'h0, d[27]});
		wr(8'h80, 32'h80801001);
		rd(8'h80, d);
		chk("after rx reset", 32'h0, {30'h0, d[27:26]});
		@(posedge clk_sys);
		rxBadToken <= 8'h01;
		@(posedge clk_sys);
		rxBadToken <= 8'h00;
		rd(8'h80, d);
		chk("bad token flag", 32'h1, {31'h0, d[27]});
		slow <= 1'b1;
		wr(8'h80, 32'h81001001);
		txSymReq <= 8'h01;
		rd(8'h80, d);
		chk("credit cleared", 32'h0, {31'h0, d[25]});
		@(negedge clk_sys);
		chk("no credit no go", 32'h0, {31'h0, txSymGo[0]});
		wait_cred(d);
		@(posedge clk_sys);
		txSymReq <= 8'h00;
		$display("test credit done");
	endtask

	task automatic t_debug();
		logic [31:0] d;
		for (int k = 1; k < 4; k++) begin
			@(posedge clk_sys);
			{dbgEvtCore1, dbgEvtCore0} <= 2'(k);
			@(posedge clk_sys);
			{dbgEvtCore1, dbgEvtCore0} <= 2'h0;
			rd(8'h1f, d);
			chk("debug source", 32'(k), d);
		end
		wr(8'h1f, 32'hffffffff);
		rd(8'h1f, d);
		chk("debug rw bits", 32'h13, d);
		$display("test debug done");
	endtask

	task automatic t_static();
		logic [31:0] d;
		for (int i = 0; i < 8; i++) begin
			wr(8'ha0 + 8'(i), {1'b1, 22'h3fffff, i[0], 3'h7, 5'(i + 3)});
			rd(8'ha0 + 8'(i), d);
			chk("static reg", {1'b1, 22'h0, i[0], 3'h0, 5'(i + 3)}, d);
			chk("static port", {25'h0, 1'b1, i[0], 5'(i + 3)},
				{25'h0, staticEn[i ^ 2], staticProc[i ^ 2], staticChan[i ^ 2]});
		end
		$display("test static done");
	endtask

	task automatic t_route();
		wr(8'h0c, 32'h76543210);
		wr(8'h0d, 32'hfedcba98);
		for (int b = 0; b < 16; b++) begin
			@(posedge clk_sys);
			pktDestNode <= nodeId ^ ((16'h0002 << b) - 16'h0001);
			@(posedge clk_sys);
			#1;
			chk("route dir", 32'(b), {27'h0, routeLocal, routeDir});
		end
		@(posedge clk_sys);
		pktDestNode <= nodeId;
		@(posedge clk_sys);
		#1;
		chk("route local", 32'h10, {27'h0, routeLocal, routeDir});
		$display("test route done");
	endtask

	// main sequence
	initial begin
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		t_reset();
		t_status();
		t_cfg();
		t_credit();
		t_debug();
		t_static();
		t_route();
		print_verdict();
	end
endmodule

`default_nettype wire

// file: verilog/slc_link_cfg.sv
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "slc_defs.svh"

module slc_link_cfg
	import slc_pkg::*;
(
	input  wire logic             clk_sys,
	input  wire logic             reset,
	// register port
	input  wire logic [7:0]       regAddr,
	input  wire logic [31:0]      regWrData,
	input  wire logic             regWrStb,
	input  wire logic             regRdStb,
	output logic      [31:0]      regRdData,
	// debug event source
	input  wire logic             dbgEvtCore0,
	input  wire logic             dbgEvtCore1,
	// per external link status from the switch fabric
	input  wire logic [7:0][1:0]  extTgtType,
	input  wire logic [7:0][7:0]  extDestLink,
	input  wire logic [7:0]       extJunk,
	input  wire logic [7:0]       extDestBusy,
	input  wire logic [7:0]       extSrcBusy,
	output logic      [7:0][3:0]  extDirection,
	output logic      [7:0][1:0]  extNetwork,
	// per processor link status
	input  wire logic [7:0][1:0]  procTgtType,
	input  wire logic [7:0][7:0]  procDestLink,
	input  wire logic [7:0]       procJunk,
	input  wire logic [7:0]       procDestBusy,
	input  wire logic [7:0]       procSrcBusy,
	output logic      [7:0][1:0]  procNetwork,
	// per external link serial engine
	input  wire logic [7:0]       rxOverflow,
	input  wire logic [7:0]       rxBadToken,
	input  wire logic [7:0]       rxCreditIn,
	input  wire logic [7:0]       rxHelloIn,
	input  wire logic [7:0]       txSymReq,
	input  wire logic [7:0]       txSymLast,
	output logic      [7:0]       txSymGo,
	output logic      [7:0]       txHelloSend,
	output logic      [7:0]       txCreditSend,
	output logic      [7:0]       rxResetPulse,
	output logic      [7:0]       linkEnable,
	output logic      [7:0]       linkWire5,
	// static forwarding, indexed by link A..H as 0..7
	output logic      [7:0]       staticEn,
	output logic      [7:0]       staticProc,
	output logic      [7:0][4:0]  staticChan,
	// routing lookup
	input  wire logic [15:0]      nodeId,
	input  wire logic [15:0]      pktDestNode,
	output logic      [3:0]       routeDir,
	output logic                  routeLocal
);

	// register storage
	logic [1:0]            rsvdA_ff;       // spare control pair a
	logic [1:0]            rsvdB_ff;       // spare control pair b
	logic [2:0]            dbgSrc_ff;      // spare, core1, core0
	slc_dir_t [15:0]       dirTab_ff;      // direction per mismatch bit
	slc_dir_t [7:0]        extDir_ff;      // external link direction
	slc_net_t [7:0]        extNet_ff;      // external link network
	slc_net_t [7:0]        procNet_ff;     // processor link network
	logic [7:0]            lnkEn_ff;       // link enable
	logic [7:0]            lnkW5_ff;       // 5 wire mode
	logic [7:0]            lnkErr_ff;      // sticky receive error
	logic [7:0]            credOut_ff;     // credit granted to remote
	logic [7:0]            credIn_ff;      // credit held from remote
	slc_gap_t [7:0]        symGap_ff;      // idle between symbols
	slc_gap_t [7:0]        tokGap_ff;      // idle between tokens
	logic [7:0]            stEn_ff;        // static enable per register
	logic [7:0]            stProc_ff;      // static processor per register
	logic [7:0][4:0]       stChan_ff;      // static channel per register
	logic [7:0]            credit_request_token_ff;       // credit_request_token request pulse
	logic [7:0]            rxRst_ff;       // receiver reset pulse
	logic [7:0]            credSend_ff;    // credit issue pulse
	logic [31:0]           rdData_ff;      // read answer
	logic [3:0]            routeDir_ff;    // lookup result
	logic                  routeLocal_ff;  // packet is for this node
	logic [31:0]           nxt_rdData;     // read mux result

	// decoded strobes
	logic [2:0]  regIdx;                   // link index in group
	logic        wrLstat;                  // write to link status group
	logic        wrPstat;                  // write to processor status group
	logic        wrLcfg;                   // write to link config group
	logic        wrStat;                   // write to static group

	assign regIdx  = regAddr[2:0];
	assign wrLstat = regWrStb && (regAddr[7:3] == 5'(`SLC_ADR_LSTAT_BASE >> 3));
	assign wrPstat = regWrStb && (regAddr[7:3] == 5'(`SLC_ADR_PSTAT_BASE >> 3));
	assign wrLcfg  = regWrStb && (regAddr[7:3] == 5'(`SLC_ADR_LCFG_BASE >> 3));
	assign wrStat  = regWrStb && (regAddr[7:3] == 5'(`SLC_ADR_STAT_BASE >> 3));

	// spare control pairs, only bits 1:0 writable
	// spare bits kept
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rsvdA_ff <= 2'h0;
			rsvdB_ff <= 2'h0;
		end else if (regWrStb && regAddr == `SLC_ADR_RSVD_A) begin
			rsvdA_ff <= regWrData[1:0];
		end else if (regWrStb && regAddr == `SLC_ADR_RSVD_B) begin
			rsvdB_ff <= regWrData[1:0];
		end
	end

	// debug source: event replaces record, event beats software
	// record event core
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			dbgSrc_ff <= 3'h0;
		end else if (dbgEvtCore0 || dbgEvtCore1) begin
			dbgSrc_ff[`SLC_DS_CORE1] <= dbgEvtCore1;
			dbgSrc_ff[`SLC_DS_CORE0] <= dbgEvtCore0;
		end else if (regWrStb && regAddr == `SLC_ADR_DBG_SRC) begin
			dbgSrc_ff[2] <= regWrData[`SLC_DS_SPARE];
			dbgSrc_ff[`SLC_DS_CORE1] <= regWrData[`SLC_DS_CORE1];
			dbgSrc_ff[`SLC_DS_CORE0] <= regWrData[`SLC_DS_CORE0];
		end
	end

	// direction table, two words of eight nibbles
	// table entries
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			dirTab_ff <= '0;
		end else if (regWrStb && regAddr == `SLC_ADR_DIR_LO) begin
			dirTab_ff[7:0] <= regWrData;
		end else if (regWrStb && regAddr == `SLC_ADR_DIR_HI) begin
			dirTab_ff[15:8] <= regWrData;
		end
	end

	// per link writable fields of the status groups
	// direction field
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			extDir_ff <= {8{`SLC_RST_DIR}};
			extNet_ff <= {8{`SLC_RST_NET}};
		end else if (wrLstat) begin
			extDir_ff[regIdx] <= regWrData[`SLC_ST_DIR_LSB +: 4];
			extNet_ff[regIdx] <= regWrData[`SLC_ST_NET_LSB +: 2];
		end
	end

	// processor link network numbers
	// processor status group
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			procNet_ff <= {8{`SLC_RST_NET}};
		end else if (wrPstat) begin
			procNet_ff[regIdx] <= regWrData[`SLC_ST_NET_LSB +: 2];
		end
	end

	// link configuration writable fields
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			lnkEn_ff  <= 8'h00;
			lnkW5_ff  <= 8'h00;
			symGap_ff <= {8{`SLC_RST_GAP}};
			tokGap_ff <= {8{`SLC_RST_GAP}};
		end else if (wrLcfg) begin
			lnkEn_ff[regIdx]  <= regWrData[`SLC_CF_EN];
			lnkW5_ff[regIdx]  <= regWrData[`SLC_CF_WIRE5];
			symGap_ff[regIdx] <= regWrData[`SLC_CF_SGAP_LSB +: 11];
			tokGap_ff[regIdx] <= regWrData[`SLC_CF_TGAP_LSB +: 11];
		end
	end

	// command pulses from write-only bits, one cycle each
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			credit_request_token_ff <= 8'h00;
			rxRst_ff <= 8'h00;
		end else begin
			for (int i = 0; i < 8; i++) begin
				credit_request_token_ff[i] <= wrLcfg && regIdx == 3'(i) && regWrData[`SLC_CF_CREDIT_REQUEST_TOKEN];
				rxRst_ff[i] <= wrLcfg && regIdx == 3'(i) && regWrData[`SLC_CF_RXRST];
			end
		end
	end

	// sticky receive error, set wins over receiver reset
	// error flag
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			lnkErr_ff <= 8'h00;
		end else begin
			lnkErr_ff <= (lnkErr_ff & ~rxRst_ff) | rxOverflow | rxBadToken;
		end
	end

	// credit held from remote: cleared by credit_request_token command, set wins
	// held credit
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			credIn_ff <= 8'h00;
		end else begin
			credIn_ff <= (credIn_ff & ~credit_request_token_ff) | (rxCreditIn & lnkEn_ff);
		end
	end

	// answer a received credit_request_token by granting credit once
	// credit granted
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			credOut_ff  <= 8'h00;
			credSend_ff <= 8'h00;
		end else begin
			credSend_ff <= rxHelloIn & lnkEn_ff;
			credOut_ff  <= (credOut_ff & ~rxRst_ff & lnkEn_ff) | (rxHelloIn & lnkEn_ff);
		end
	end

	// static forwarding registers
	// static target
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			stEn_ff   <= 8'h00;
			stProc_ff <= 8'h00;
			stChan_ff <= {8{`SLC_RST_CHAN}};
		end else if (wrStat) begin
			stEn_ff[regIdx]   <= regWrData[`SLC_SF_EN];
			stProc_ff[regIdx] <= regWrData[`SLC_SF_PROC];
			stChan_ff[regIdx] <= regWrData[`SLC_SF_CHAN_LSB +: 5];
		end
	end

	// per link transmit pacing
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : gLink
			slc_cnt_t idleCnt_ff;   // idle cycles still owed
			assign txSymGo[g] = txSymReq[g] && lnkEn_ff[g] && credIn_ff[g]
				&& idleCnt_ff == '0;
			// load owed idle cycles after each symbol
			always_ff @(posedge clk_sys) begin
				if (reset) begin
					idleCnt_ff <= '0;
				end else if (txSymGo[g]) begin
					if (txSymLast[g]) begin
						idleCnt_ff <= {1'b0, tokGap_ff[g]} + 12'h001;
					end else begin
						idleCnt_ff <= {1'b0, symGap_ff[g]} + 12'h001;
					end
				end else if (idleCnt_ff != '0) begin
					idleCnt_ff <= idleCnt_ff - 12'h001;
				end
			end
		end
	endgenerate

	// routing lookup on most significant mismatching bit
	// route lookup
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			routeDir_ff   <= `SLC_RST_DIR;
			routeLocal_ff <= 1'b0;
		end else begin
			routeLocal_ff <= (nodeId == pktDestNode);
			routeDir_ff   <= `SLC_RST_DIR;
			for (int b = 0; b < 16; b++) begin
				if (nodeId[b] != pktDestNode[b]) begin
					routeDir_ff <= dirTab_ff[b];
				end
			end
		end
	end

	// read multiplexer, unmapped addresses read zero, spare pairs read back bits 1:0
	// zero fill
	always_comb begin
		nxt_rdData = 32'h0000_0000;
		if (regAddr == `SLC_ADR_RSVD_A) begin
			nxt_rdData[1:0] = rsvdA_ff;
		end else if (regAddr == `SLC_ADR_RSVD_B) begin
			nxt_rdData[1:0] = rsvdB_ff;
		end else if (regAddr == `SLC_ADR_DBG_SRC) begin
			nxt_rdData[`SLC_DS_SPARE] = dbgSrc_ff[2];
			nxt_rdData[`SLC_DS_CORE1] = dbgSrc_ff[`SLC_DS_CORE1];
			nxt_rdData[`SLC_DS_CORE0] = dbgSrc_ff[`SLC_DS_CORE0];
		end else if (regAddr == `SLC_ADR_DIR_LO) begin
			nxt_rdData = dirTab_ff[7:0];
		end else if (regAddr == `SLC_ADR_DIR_HI) begin
			nxt_rdData = dirTab_ff[15:8];
		end else if (regAddr[7:3] == 5'(`SLC_ADR_LSTAT_BASE >> 3)) begin
			nxt_rdData[`SLC_ST_TGT_LSB +: 2]  = extTgtType[regIdx];
			nxt_rdData[`SLC_ST_DEST_LSB +: 8] = extDestLink[regIdx];
			nxt_rdData[`SLC_ST_DIR_LSB +: 4]  = extDir_ff[regIdx];
			nxt_rdData[`SLC_ST_NET_LSB +: 2]  = extNet_ff[regIdx];
			nxt_rdData[`SLC_ST_JUNK]  = extJunk[regIdx];
			nxt_rdData[`SLC_ST_DBUSY] = extDestBusy[regIdx];
			nxt_rdData[`SLC_ST_SBUSY] = extSrcBusy[regIdx];
		end else if (regAddr[7:3] == 5'(`SLC_ADR_PSTAT_BASE >> 3)) begin
			nxt_rdData[`SLC_ST_TGT_LSB +: 2]  = procTgtType[regIdx];
			nxt_rdData[`SLC_ST_DEST_LSB +: 8] = procDestLink[regIdx];
			nxt_rdData[`SLC_ST_NET_LSB +: 2]  = procNet_ff[regIdx];
			nxt_rdData[`SLC_ST_JUNK]  = procJunk[regIdx];
			nxt_rdData[`SLC_ST_DBUSY] = procDestBusy[regIdx];
			nxt_rdData[`SLC_ST_SBUSY] = procSrcBusy[regIdx];
		end else if (regAddr[7:3] == 5'(`SLC_ADR_LCFG_BASE >> 3)) begin
			nxt_rdData[`SLC_CF_EN]       = lnkEn_ff[regIdx];
			nxt_rdData[`SLC_CF_WIRE5]    = lnkW5_ff[regIdx];
			nxt_rdData[`SLC_CF_ERR]      = lnkErr_ff[regIdx];
			nxt_rdData[`SLC_CF_CRED_OUT] = credOut_ff[regIdx];
			nxt_rdData[`SLC_CF_CRED_IN]  = credIn_ff[regIdx];
			nxt_rdData[`SLC_CF_SGAP_LSB +: 11] = symGap_ff[regIdx];
			nxt_rdData[`SLC_CF_TGAP_LSB +: 11] = tokGap_ff[regIdx];
		end else if (regAddr[7:3] == 5'(`SLC_ADR_STAT_BASE >> 3)) begin
			nxt_rdData[`SLC_SF_EN]   = stEn_ff[regIdx];
			nxt_rdData[`SLC_SF_PROC] = stProc_ff[regIdx];
			nxt_rdData[`SLC_SF_CHAN_LSB +: 5] = stChan_ff[regIdx];
		end
	end

	// read data stands one cycle after the strobe only
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rdData_ff <= 32'h0000_0000;
		end else if (regRdStb) begin
			rdData_ff <= nxt_rdData;
		end else begin
			rdData_ff <= 32'h0000_0000;
		end
	end

	// static register order to link letters: C D A B G H E F
	// link order
	always_comb begin
		staticEn   = '0;
		staticProc = '0;
		staticChan = '0;
		for (int r = 0; r < 8; r++) begin
			// link = register index with pairs swapped (bit 1 flipped)
			// static forward
			staticEn[r ^ 2]   = stEn_ff[r];
			staticProc[r ^ 2] = stProc_ff[r];
			staticChan[r ^ 2] = stChan_ff[r];
		end
	end

	// outputs
	assign regRdData    = rdData_ff;
	assign extDirection = extDir_ff;
	assign extNetwork   = extNet_ff;
	assign procNetwork  = procNet_ff;
	assign txHelloSend  = credit_request_token_ff;
	assign txCreditSend = credSend_ff;
	assign rxResetPulse = rxRst_ff;
	assign linkEnable   = lnkEn_ff;
	assign linkWire5    = lnkW5_ff;
	assign routeDir     = routeDir_ff;
	assign routeLocal   = routeLocal_ff;

endmodule

`default_nettype wire
